/* verilog/obrbd_pkg.sv */
// Purpose: shared constants and carriers for the off-board ram bank decoder
// Assumes: 16-bit byte address bus, msb-first bit numbering on the bus side
// Notes: bank n covers 1k words (2k bytes)
package obrbd_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BANK_N = 8;
    localparam int BANK_WORDS = 1024;
    localparam int WORD_AW = 10;
    localparam logic [1:0] BOARD_SEL = 2'h3;
    localparam logic [2:0] TOP_BANK_CODE = 3'h5;
    localparam logic [2:0] ONBOARD_LO_CODE = 3'h6;
    localparam logic [7:0] STD_BANK_MASK = 8'h3f;
    localparam logic [7:0] ALL_BANK_MASK = 8'hff;
    localparam logic [15:0] LOW_BANK_BASE = 16'hc000;
    localparam logic [15:0] TOP_BANK_BASE = 16'he800;
    localparam logic [15:0] ONBOARD_BASE = 16'hf000;
    localparam int WAIT_STATES = 1;

    typedef struct packed {
        logic memen;
        logic we;
        logic dbin;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } obrbd_bus_t;

    typedef struct packed {
        logic ready;
        logic rdata_oe;
        logic [DATA_W-1:0] rdata;
    } obrbd_resp_t;
endpackage

/* verilog/obrbd_bank.sv */
// Purpose: one 1k x 16 expansion ram bank
// Assumes: write on we with select, read data registered
// Notes: used once per bank select
`timescale 1ns/10ps
module obrbd_bank #(
    parameter int WORDS = 1024,
    parameter int AW = 10,
    parameter int DW = 16
) (
    input wire logic CLK,
    input wire logic SEL,
    input wire logic WE,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] WDATA,
    output logic [DW-1:0] RDATA
);
    logic [DW-1:0] mem [WORDS];
    always_ff @(posedge CLK) begin
        if (SEL && WE) begin
            mem[ADDR] <= WDATA;
        end
        RDATA <= mem[ADDR];
    end
endmodule

/* verilog/obrbd_top.sv */
// Purpose: bank decode, wait-state and ram banks of an expansion memory board
// Assumes: CLK is the bus phase-one clock; bus inputs are synchronous to it
// Notes: eight banks when ALL_BANKS_EN is high, six otherwise
`timescale 1ns/10ps
module obrbd_top
    import obrbd_pkg::*;
#(
    parameter int NBANK = BANK_N
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic ALL_BANKS_EN,
    input wire obrbd_pkg::obrbd_bus_t BUS,
    output obrbd_pkg::obrbd_resp_t RESP,
    output logic [NBANK-1:0] BANK_SEL
);
    import obrbd_pkg::*;

    typedef enum logic [2:0] {
        OBRBD_IDLE = 3'b001,
        OBRBD_WAIT = 3'b010,
        OBRBD_LAST = 3'b100
    } obrbd_state_t;

    obrbd_state_t state, next_state;
    logic [4:0] top5;
    logic board_hit;
    logic [NBANK-1:0] dec, bank_mask;
    logic hit;
    logic [2:0] bank_idx, next_bank_idx;
    logic [DATA_W-1:0] rdata_bank [NBANK];
    logic [NBANK-1:0] next_bank_sel;

    assign top5 = BUS.addr[ADDR_W-1 -: 5];
    assign board_hit = (top5[4:3] == BOARD_SEL);
    assign bank_mask = ALL_BANKS_EN ? ALL_BANK_MASK : STD_BANK_MASK;

    always_comb begin
        dec = '0;
        dec[top5[2:0]] = board_hit;
        dec = dec & bank_mask;
    end
    assign hit = BUS.memen && (|dec);

    always_comb begin
        next_state = state;
        next_bank_idx = bank_idx;
        next_bank_sel = BANK_SEL;
        unique case (state)
            OBRBD_IDLE: begin
                if (hit) begin
                    next_state = OBRBD_WAIT;
                    next_bank_idx = top5[2:0];
                    next_bank_sel = dec;
                end
            end
            OBRBD_WAIT: begin
                next_state = OBRBD_LAST;
            end
            OBRBD_LAST: begin
                next_state = OBRBD_IDLE;
                next_bank_sel = '0;
            end
            default: begin
                next_state = OBRBD_IDLE;
                next_bank_sel = '0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state <= OBRBD_IDLE;
            bank_idx <= 3'h0;
            BANK_SEL <= '0;
        end else begin
            state <= next_state;
            bank_idx <= next_bank_idx;
            BANK_SEL <= next_bank_sel;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NBANK; g++) begin : g_bank
            obrbd_bank #(.WORDS(BANK_WORDS), .AW(WORD_AW), .DW(DATA_W)) u_bank (
                .CLK(CLK),
                .SEL(BANK_SEL[g] && state == OBRBD_WAIT),
                .WE(!BUS.we),
                .ADDR(BUS.addr[WORD_AW:1]),
                .WDATA(BUS.wdata),
                .RDATA(rdata_bank[g])
            );
        end
    endgenerate

    // ready low during wait state; host holds the cycle meanwhile
    assign RESP.ready = !(state == OBRBD_WAIT) && !(state == OBRBD_IDLE && hit);
    assign RESP.rdata_oe = (state == OBRBD_LAST) && BUS.dbin;
    assign RESP.rdata = rdata_bank[bank_idx];

    a_one_wait: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && hit) |=> (state == OBRBD_WAIT && !RESP.ready) ##1 RESP.ready)
        else $error("wait state count wrong");
    a_ready_start: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && hit) |-> !RESP.ready)
        else $error("ready not low at cycle start");
    a_upper_unused: assert property (@(posedge CLK) disable iff (!RSTN)
        (!ALL_BANKS_EN && BUS.addr >= ONBOARD_BASE) |-> !hit)
        else $error("decoder hit on-board region");
    a_top_bank: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && BUS.memen && BUS.addr >= TOP_BANK_BASE && BUS.addr < ONBOARD_BASE)
        |=> BANK_SEL == 8'h20)
        else $error("top bank not selected");
    a_low_bank: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && BUS.memen && BUS.addr[15:11] == 5'h18) |=> BANK_SEL == 8'h01)
        else $error("lowest bank not selected");
    a_below_board: assert property (@(posedge CLK) disable iff (!RSTN)
        (BUS.addr < LOW_BANK_BASE) |-> !hit)
        else $error("hit below board region");
    a_all_banks: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && ALL_BANKS_EN && BUS.memen && BUS.addr[15:11] == 5'h1f)
        |=> BANK_SEL == 8'h80)
        else $error("eighth bank not selected");
    a_one_hot_sel: assert property (@(posedge CLK) disable iff (!RSTN)
        $onehot0(BANK_SEL))
        else $error("more than one bank selected");
    a_sel_drop: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_LAST) |=> BANK_SEL == '0)
        else $error("select held past cycle");

    // wait-state sequencing
    a_hit_to_wait: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && hit) |=> (state == OBRBD_WAIT))
        else $error("selected cycle did not enter wait");
    a_wait_ready_low: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_WAIT) |-> !RESP.ready)
        else $error("ready high in wait state");
    a_wait_to_last: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_WAIT) |=> (state == OBRBD_LAST))
        else $error("wait state repeated");
    a_last_to_idle: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_LAST) |=> (state == OBRBD_IDLE))
        else $error("final state not left");
    a_ready_idle: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && !hit) |-> RESP.ready)
        else $error("ready low without selected cycle");
    a_ready_last: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_LAST) |-> RESP.ready)
        else $error("ready low in final state");
    a_memen_gate: assert property (@(posedge CLK) disable iff (!RSTN)
        (!BUS.memen) |-> !hit)
        else $error("hit without memory cycle");
    a_state_legal: assert property (@(posedge CLK) disable iff (!RSTN)
        $onehot(state))
        else $error("illegal state code");

    // address decode
    a_five_line_hit: assert property (@(posedge CLK) disable iff (!RSTN)
        (BUS.memen && BUS.addr[15:14] == BOARD_SEL && (ALL_BANKS_EN || BUS.addr[13:11] < ONBOARD_LO_CODE)) |-> hit)
        else $error("enabled bank address missed");
    a_board_lines: assert property (@(posedge CLK) disable iff (!RSTN)
        (BUS.addr[15:14] != BOARD_SEL) |-> !hit)
        else $error("hit outside board lines");
    a_bank_code: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && hit) |=> BANK_SEL[bank_idx])
        else $error("select does not match bank index");
    a_hit_sel: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && hit) |=> (BANK_SEL == $past(dec)))
        else $error("select not taken from decode");
    a_miss_stays: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && BUS.memen && !hit) |=> (state == OBRBD_IDLE))
        else $error("cycle started on a miss");
    a_top_code: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && hit && BUS.addr[13:11] == TOP_BANK_CODE) |=> BANK_SEL[TOP_BANK_CODE])
        else $error("top bank code not selected");
    a_onboard_mask: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && hit && !ALL_BANKS_EN) |=> ((BANK_SEL & ~STD_BANK_MASK) == '0))
        else $error("on-board region selected in six-bank map");
    a_mid_bank: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && BUS.memen && BUS.addr[15:11] == 5'h1a) |=> BANK_SEL == 8'h04)
        else $error("third bank not selected");
    a_below_sel: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE && BUS.addr < LOW_BANK_BASE) |=> (BANK_SEL == '0))
        else $error("select below lowest bank");
    a_eight_hit: assert property (@(posedge CLK) disable iff (!RSTN)
        (ALL_BANKS_EN && BUS.memen && BUS.addr >= ONBOARD_BASE) |-> hit)
        else $error("upper banks missed in eight-bank map");

    // bank select and read data
    a_sel_idle_zero: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_IDLE) |-> (BANK_SEL == '0))
        else $error("select active while idle");
    a_sel_busy: assert property (@(posedge CLK) disable iff (!RSTN)
        (state != OBRBD_IDLE) |-> (BANK_SEL != '0))
        else $error("no select during cycle");
    a_sel_held: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_WAIT) |=> $stable(BANK_SEL))
        else $error("select changed inside cycle");
    a_idx_held: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_WAIT) |=> $stable(bank_idx))
        else $error("bank index changed inside cycle");
    a_oe_read: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == OBRBD_LAST && BUS.dbin) |-> RESP.rdata_oe)
        else $error("read data not enabled in final state");
    a_oe_last_only: assert property (@(posedge CLK) disable iff (!RSTN)
        (state != OBRBD_LAST) |-> !RESP.rdata_oe)
        else $error("read data enabled outside final state");

    c_read: cover property (@(posedge CLK) disable iff (!RSTN) state == OBRBD_LAST && BUS.dbin);
    c_write: cover property (@(posedge CLK) disable iff (!RSTN) state == OBRBD_WAIT && !BUS.we);
    c_eight: cover property (@(posedge CLK) disable iff (!RSTN) BANK_SEL[7]);
    c_back: cover property (@(posedge CLK) disable iff (!RSTN) state == OBRBD_LAST ##1 hit);
    c_miss: cover property (@(posedge CLK) disable iff (!RSTN) state == OBRBD_IDLE && BUS.memen && !hit);
endmodule

/* testbench/obrbd_host.sv */
// Purpose: host bus master model issuing memory cycles
// Assumes: bus driven at falling edge, held until after the final state
// Notes: released address and data show the inverse value
`timescale 1ns/10ps
module obrbd_host
    import obrbd_pkg::*;
(
    input wire logic CLK,
    input wire obrbd_pkg::obrbd_resp_t RESP,
    input wire logic [7:0] SEL_MON,
    output obrbd_pkg::obrbd_bus_t BUS
);
    initial BUS = '0;
    task automatic cycle(input logic [15:0] a, input logic wr, input logic [15:0] wd, output logic r0,
                         output int nw, output logic oe, output logic [15:0] rd, output logic [7:0] sel);
        @(negedge CLK);
        BUS.memen = 1'b1;
        BUS.addr = a;
        BUS.we = ~wr;
        BUS.dbin = ~wr;
        BUS.wdata = wd;
        #1 r0 = RESP.ready;
        nw = 0;
        @(negedge CLK);
        sel = SEL_MON;
        while (RESP.ready !== 1'b1 && nw < 4) begin
            nw++;
            @(negedge CLK);
        end
        oe = RESP.rdata_oe;
        rd = RESP.rdata;
        @(negedge CLK);
        BUS.memen = 1'b0;
        BUS.addr = ~a;
        BUS.wdata = ~wd;
        BUS.we = 1'b1;
        BUS.dbin = 1'b0;
    endtask
endmodule

/* testbench/tb_offboard_ram_bank_decoder.sv */
// Purpose: self-checking bench for the expansion ram bank decoder
// Assumes: host model drives every memory cycle
// Notes: six-bank and eight-bank maps both exercised
`timescale 1ns/10ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb_offboard_ram_bank_decoder;
    import obrbd_pkg::*;
    logic CLK = 0, RSTN = 0, ALL_BANKS_EN = 0;
    obrbd_bus_t bus;
    obrbd_resp_t resp;
    logic [7:0] bank_sel;
    int n_mismatch = 0, checks = 0, cyc = 0;
    always #2.5 CLK = ~CLK;
    obrbd_top uut (.CLK(CLK), .RSTN(RSTN), .ALL_BANKS_EN(ALL_BANKS_EN), .BUS(bus), .RESP(resp), .BANK_SEL(bank_sel));
    obrbd_host host (.CLK(CLK), .RESP(resp), .SEL_MON(bank_sel), .BUS(bus));
    task automatic acc(input logic [15:0] a, input logic wr, input logic [15:0] wd, input int b);
        logic r0, oe;
        int nw;
        logic [15:0] rd;
        logic [7:0] sel;
        host.cycle(a, wr, wd, r0, nw, oe, rd, sel);
        if (b < 0) begin
            `CHK(r0, 1'b1, "ready dropped on miss")
            `CHK(nw, 0, "wait on miss")
            `CHK(sel, 8'h00, "select on miss")
            `CHK(oe, 1'b0, "read enable on miss")
        end else begin
            `CHK(r0, 1'b0, "ready high at cycle start")
            `CHK(nw, 1, "wait count")
            `CHK(sel, 8'(1 << b), "bank select")
            `CHK(oe, ~wr, "read enable")
            if (!wr) `CHK(rd, wd, "read data")
        end
    endtask
    task automatic t_six_banks();
        for (int b = 0; b < 6; b++) begin
            acc(16'hc000 + 16'(b * 16'h800), 1, 16'h1100 + 16'(b), b);
            acc(16'hc7fe + 16'(b * 16'h800), 1, 16'h2200 + 16'(b), b);
        end
        for (int b = 0; b < 6; b++) begin
            acc(16'hc000 + 16'(b * 16'h800), 0, 16'h1100 + 16'(b), b);
            acc(16'hc7fe + 16'(b * 16'h800), 0, 16'h2200 + 16'(b), b);
        end
        acc(16'he801, 0, 16'h1105, 5);
        $display("test six banks done");
    endtask
    task automatic t_refused();
        acc(16'hf000, 0, 16'h0000, -1);
        acc(16'hfffe, 1, 16'h5a5a, -1);
        acc(16'hbffe, 0, 16'h0000, -1);
        acc(16'h0000, 1, 16'ha5a5, -1);
        $display("test refused done");
    endtask
    task automatic t_eight_banks();
        @(negedge CLK);
        ALL_BANKS_EN = 1'b1;
        acc(16'hf000, 1, 16'h3306, 6);
        acc(16'hfffe, 1, 16'h3307, 7);
        acc(16'hf000, 0, 16'h3306, 6);
        acc(16'hfffe, 0, 16'h3307, 7);
        acc(16'hb000, 0, 16'h0000, -1);
        acc(16'hc000, 0, 16'h1100, 0);
        $display("test eight banks done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(negedge CLK);
        RSTN = 1'b1;
        t_six_banks();
        t_refused();
        t_eight_banks();
        complete_run();
    end
endmodule
